// ### hdl/synth_cfg_map.svh
// constants of the serial configuration loader: word layout, defaults, register map
// assumes inclusion by bare name from the package and the design modules
`ifndef SYNTH_CFG_MAP_SVH
`define SYNTH_CFG_MAP_SVH

// control word
`define CW_BITS        132
`define CW_DEFAULT     132'h203ffc00840000000000000000000600c

// control word field positions
`define FB_LSB         0
`define FB_MSB         11
`define REF_LSB        12
`define REF_MSB        23
`define OD3_LOW_BIT    94
`define OD1_LSB        98
`define OD1_MSB        109
`define OE1_BIT        110
`define OE2_BIT        111
`define RUN_BIT        112
`define OD2_LOW_BIT    113
`define OD2_HI_LSB     114
`define OD2_HI_MSB     117
`define OD3_HI_LSB     118
`define OD3_HI_MSB     121
`define XTAL_BIT       122
`define SRC2_BIT       123
`define SRC3_BIT       124
`define OE3_BIT        129

// divider limits
`define FB_MIN         12'h00c
`define FB_MAX         12'h807
`define REF_MIN        12'h001
`define REF_MAX        12'h807

// register byte offsets
`define ADDR_ACT0      8'h00
`define ADDR_ACT1      8'h04
`define ADDR_ACT2      8'h08
`define ADDR_ACT3      8'h0c
`define ADDR_ACT4      8'h10
`define ADDR_STATUS    8'h14
`define ADDR_CTRL      8'h18
`define ADDR_DIV       8'h1c
`define ADDR_OD        8'h20

// control and status bits
`define CTRL_SOFT_PD   0
`define CTRL_CLR_CNT   1
`define STAT_RUN       0
`define STAT_STROBE    1
`define STAT_PIN_UP    2
`define STAT_FB_CLAMP  3
`define STAT_REF_CLAMP 4
`define STAT_CNT_LSB   16

`endif

// ### hdl/synth_cfg_pkg.sv
// types shared by the serial configuration loader and its helpers
// assumes the constants header is on the include path
`include "synth_cfg_map.svh"

package synth_cfg_pkg;

	// decoded active control word
	typedef struct packed {
		logic [11:0] fb_div;
		logic [11:0] ref_div;
		logic [11:0] output_divider_value;
		logic [5:0]  od2;
		logic [5:0]  od3;
		logic        first_output_enable_bit;
		logic        oe2;
		logic        oe3;
		logic        vco_run;
		logic        xtal_sel;
		logic        src2_ref;
		logic        src3_ref;
		logic        fb_clamped;
		logic        ref_clamped;
	} cfg_s;

	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b00,
		BUS_ANSWER = 2'b01
	} bus_state_e;

	// one avalon request, taken straight from the port signals without a register
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} bus_req_s;

endpackage : synth_cfg_pkg

// ### hdl/level_sync.sv
// two-flop synchroniser for slow levels entering the clk domain
// assumes inputs change far slower than clk
`timescale 1ns/1ns

module level_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	if (W < 1) begin : g_chk
		$error("level_sync width must be at least one");
	end

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : level_sync

// ### hdl/rate_tick.sv
// fractional rate generator: one tick per output cycle at rate num/den of clk
// assumes den stays nonzero while run is high; zero den gives no ticks
`timescale 1ns/1ns

module rate_tick #(
	parameter int NUM_W = 12,
	parameter int DEN_W = 24
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             run,
	input  wire logic [NUM_W-1:0] num,
	input  wire logic [DEN_W-1:0] den,
	output logic                  tick
);
	logic [DEN_W-1:0] acc_reg;
	logic [DEN_W:0]   sum;
	logic [DEN_W:0]   rem;

	if (NUM_W > DEN_W) begin : g_chk
		$error("rate_tick needs DEN_W >= NUM_W");
	end

	assign sum = {1'b0, acc_reg} + {{(DEN_W + 1 - NUM_W){1'b0}}, num};
	assign rem = sum - {1'b0, den};

	// phase is kept across rate changes so the rate slews without a restart
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= '0;
			tick    <= 1'b0;
		end else if (!run || den == '0) begin
			tick <= 1'b0;
		end else if (sum >= {1'b0, den}) begin
			tick <= 1'b1;
			// ratio above one saturates at one tick per cycle
			acc_reg <= (rem >= {1'b0, den}) ? '0 : rem[DEN_W-1:0];
		end else begin
			tick    <= 1'b0;
			acc_reg <= sum[DEN_W-1:0];
		end
	end
endmodule : rate_tick

// ### hdl/clock_synth_loader.sv
// serial control word loader with decoded divider set and rate ticks
// assumes serial_clk is the host's programming clock, idle outside frames,
// and load_strobe stays high at least three clk periods
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "synth_cfg_map.svh"

// How it works
// - 132-bit shift register, MSB arrives first
// - serial data captured on serial clock rise
// - strobe high copies shift register into active
// - loading works even while powered down
// - feedback/reference changes slew rate without restart
// - output divider changes may glitch, accepted
// - reset word gives 1x, 0.5x, 0.5x
// - defaults make first output equal input
// - first rate is input*V/(R*OD)
// - feedback divider kept within 12 to 2055
// - reference divider kept within 1 to 2055
// - bit 112 low stops feedback and oscillator
// - bit 110 gates the first output
module clock_synth_loader #(
	parameter int CW_BITS = `CW_BITS,
	parameter int CNT_W   = 16
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               serial_clk,
	input  wire logic               serial_data,
	input  wire logic               load_strobe,
	input  wire logic               power_down_pin_n,
	input  wire logic [7:0]         address,
	input  wire logic               read,
	input  wire logic               write,
	input  wire logic [31:0]        writedata,
	output logic      [31:0]        readdata,
	output logic                    waitrequest,
	output logic                    first_clock_output,
	output logic                    second_clock_output,
	output logic                    third_clock_output,
	output logic                    pll_running,
	output synth_cfg_pkg::cfg_s     decoded_cfg
);
	import synth_cfg_pkg::*;

	if (CW_BITS != `CW_BITS) begin : g_chk_cw
		$error("control word length is fixed by the field layout");
	end
	if (CNT_W < 1 || CNT_W > 16) begin : g_chk_cnt
		$error("load counter must fit the status upper half");
	end

	// serial clock domain
	logic [CW_BITS-1:0] shift_reg;

	// clk domain
	logic [CW_BITS-1:0] active_reg;
	logic [CW_BITS-1:0] active_next;
	logic               strobe_sync;
	logic               pin_up_sync;
	logic               strobe_d_reg;
	logic               load_rise;
	logic               soft_pd_reg;
	logic [CNT_W-1:0]   load_cnt_reg;
	logic               clr_cnt;
	logic               run;
	logic [23:0]        den1_reg;
	logic [23:0]        den2_reg;
	logic [23:0]        den3_reg;
	logic [11:0]        num2_reg;
	logic [11:0]        num3_reg;
	logic               gate1_reg;
	logic               gate2_reg;
	logic               gate3_reg;
	bus_state_e         bus_state_reg;
	bus_req_s           req;
	logic [31:0]        rd_mux;
	logic [31:0]        status_word;
	cfg_s               cfg_next;

	// host side shift; no reset dependence on the strobe
	always_ff @(posedge serial_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= `CW_DEFAULT;
		end else begin
			shift_reg <= {shift_reg[CW_BITS-2:0], serial_data};
		end
	end

	level_sync #(
		.W (2)
	) u_pin_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({load_strobe, power_down_pin_n}),
		.q     ({strobe_sync, pin_up_sync})
	);

	// shift_reg is quasi-static here: the host gives no serial clock edge
	// while the strobe is high, and the synchroniser delay covers settling
	always_comb begin
		active_next = active_reg;
		if (strobe_sync) begin
			active_next = shift_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_reg <= `CW_DEFAULT;
		end else begin
			active_reg <= active_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_d_reg <= 1'b0;
		end else begin
			strobe_d_reg <= strobe_sync;
		end
	end
	assign load_rise = strobe_sync && !strobe_d_reg;

	// output divide of the second and third paths: (~hi + 2) << low
	function automatic logic [5:0] od_decode(input logic [3:0] hi, input logic low);
		logic [5:0] base;
		base = {2'b00, ~hi} + 6'h02;
		od_decode = low ? {base[4:0], 1'b0} : base;
	endfunction : od_decode

	function automatic logic [11:0] clamp12(input logic [11:0] v, input logic [11:0] lo,
						input logic [11:0] hi);
		clamp12 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp12

	always_comb begin
		cfg_next = '0;
		cfg_next.fb_div = clamp12(active_reg[`FB_MSB:`FB_LSB], `FB_MIN, `FB_MAX);
		cfg_next.ref_div = clamp12(active_reg[`REF_MSB:`REF_LSB], `REF_MIN, `REF_MAX);
		cfg_next.fb_clamped = (cfg_next.fb_div != active_reg[`FB_MSB:`FB_LSB]);
		cfg_next.ref_clamped = (cfg_next.ref_div != active_reg[`REF_MSB:`REF_LSB]);
		cfg_next.output_divider_value = active_reg[`OD1_MSB:`OD1_LSB];
		cfg_next.od2 = od_decode(active_reg[`OD2_HI_MSB:`OD2_HI_LSB], active_reg[`OD2_LOW_BIT]);
		cfg_next.od3 = od_decode(active_reg[`OD3_HI_MSB:`OD3_HI_LSB], active_reg[`OD3_LOW_BIT]);
		cfg_next.first_output_enable_bit = active_reg[`OE1_BIT];
		cfg_next.oe2 = active_reg[`OE2_BIT];
		cfg_next.oe3 = active_reg[`OE3_BIT];
		cfg_next.vco_run = active_reg[`RUN_BIT];
		cfg_next.xtal_sel = active_reg[`XTAL_BIT];
		cfg_next.src2_ref = active_reg[`SRC2_BIT];
		cfg_next.src3_ref = active_reg[`SRC3_BIT];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			decoded_cfg <= '0;
		end else begin
			decoded_cfg <= cfg_next;
		end
	end

	// pin, bit 112 and the soft control all stop the loop
	assign run = decoded_cfg.vco_run && pin_up_sync && !soft_pd_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pll_running <= 1'b0;
		end else begin
			pll_running <= run;
		end
	end

	// rate of each path relative to clk taken as the input reference;
	// operands widened first so the full 24-bit product is kept
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			den1_reg <= '0;
			den2_reg <= '0;
			den3_reg <= '0;
		end else begin
			den1_reg <= 24'(decoded_cfg.ref_div) * 24'(decoded_cfg.output_divider_value);
			den2_reg <= 24'(decoded_cfg.ref_div) * 24'(decoded_cfg.od2);
			den3_reg <= 24'(decoded_cfg.ref_div) * 24'(decoded_cfg.od3);
		end
	end

	// a path sourced from the reference bypasses the feedback divider
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			num2_reg <= '0;
			num3_reg <= '0;
		end else begin
			num2_reg <= decoded_cfg.src2_ref ? decoded_cfg.ref_div : decoded_cfg.fb_div;
			num3_reg <= decoded_cfg.src3_ref ? decoded_cfg.ref_div : decoded_cfg.fb_div;
		end
	end

	// gates follow run so every path stops in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gate1_reg <= 1'b0;
			gate2_reg <= 1'b0;
			gate3_reg <= 1'b0;
		end else begin
			gate1_reg <= run && decoded_cfg.first_output_enable_bit;
			gate2_reg <= run && decoded_cfg.oe2;
			gate3_reg <= run && decoded_cfg.oe3;
		end
	end

	// feedback and reference edits only change num/den; phase carries on
	rate_tick #(
		.NUM_W (12),
		.DEN_W (24)
	) u_rate1 (
		.clk   (clk),
		.rst_n (rst_n),
		.run   (gate1_reg),
		.num   (decoded_cfg.fb_div),
		.den   (den1_reg),
		.tick  (first_clock_output)
	);

	rate_tick #(
		.NUM_W (12),
		.DEN_W (24)
	) u_rate2 (
		.clk   (clk),
		.rst_n (rst_n),
		.run   (gate2_reg),
		.num   (num2_reg),
		.den   (den2_reg),
		.tick  (second_clock_output)
	);

	rate_tick #(
		.NUM_W (12),
		.DEN_W (24)
	) u_rate3 (
		.clk   (clk),
		.rst_n (rst_n),
		.run   (gate3_reg),
		.num   (num3_reg),
		.den   (den3_reg),
		.tick  (third_clock_output)
	);

	// avalon slave: one wait cycle, then a single answer cycle
	assign req = '{read:      read,
		       write:     write,
		       address:   address,
		       writedata: writedata};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_state_reg <= BUS_IDLE;
			waitrequest   <= 1'b1;
		end else begin
			case (bus_state_reg)
				BUS_IDLE: begin
					if (req.read || req.write) begin
						bus_state_reg <= BUS_ANSWER;
						waitrequest   <= 1'b0;
					end
				end
				BUS_ANSWER: begin
					bus_state_reg <= BUS_IDLE;
					waitrequest   <= 1'b1;
				end
				default: begin
					bus_state_reg <= BUS_IDLE;
					waitrequest   <= 1'b1;
				end
			endcase
		end
	end

	// write-one clear acts on the answer edge, like every write
	assign clr_cnt = (bus_state_reg == BUS_ANSWER) && req.write &&
			 (req.address == `ADDR_CTRL) && req.writedata[`CTRL_CLR_CNT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_pd_reg <= 1'b0;
		end else if (bus_state_reg == BUS_ANSWER && req.write &&
			     req.address == `ADDR_CTRL) begin
			soft_pd_reg <= req.writedata[`CTRL_SOFT_PD];
		end
	end

	// a load in the clearing cycle still counts
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			load_cnt_reg <= '0;
		end else if (load_rise) begin
			load_cnt_reg <= clr_cnt ? CNT_W'(1) : load_cnt_reg + CNT_W'(1);
		end else if (clr_cnt) begin
			load_cnt_reg <= '0;
		end
	end

	// clamp flags tell software its word was bent into range
	always_comb begin
		status_word = '0;
		status_word[`STAT_RUN] = pll_running;
		status_word[`STAT_STROBE] = strobe_sync;
		status_word[`STAT_PIN_UP] = pin_up_sync;
		status_word[`STAT_FB_CLAMP] = decoded_cfg.fb_clamped;
		status_word[`STAT_REF_CLAMP] = decoded_cfg.ref_clamped;
		status_word[`STAT_CNT_LSB +: CNT_W] = load_cnt_reg;
	end

	always_comb begin
		case (req.address)
			`ADDR_ACT0:   rd_mux = active_reg[31:0];
			`ADDR_ACT1:   rd_mux = active_reg[63:32];
			`ADDR_ACT2:   rd_mux = active_reg[95:64];
			`ADDR_ACT3:   rd_mux = active_reg[127:96];
			`ADDR_ACT4:   rd_mux = {28'h0000000, active_reg[131:128]};
			`ADDR_STATUS: rd_mux = status_word;
			`ADDR_CTRL:   rd_mux = {31'h00000000, soft_pd_reg};
			`ADDR_DIV:    rd_mux = {4'h0, decoded_cfg.ref_div, 4'h0, decoded_cfg.fb_div};
			`ADDR_OD:     rd_mux = {2'h0, decoded_cfg.od3, 2'h0, decoded_cfg.od2,
					    4'h0, decoded_cfg.output_divider_value};
			default:      rd_mux = 32'h00000000;
		endcase
	end

	// captured on the taking edge so it stands in the answer cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata <= 32'h00000000;
		end else if (bus_state_reg == BUS_IDLE && req.read) begin
			readdata <= rd_mux;
		end
	end
endmodule : clock_synth_loader

// ### bench/host_model.sv
// host side of the three-wire programming port: shifts a word MSB first, then loads
// assumes go rises once per frame; serial clock stands low between frames
`timescale 1ns/1ns

module host_model (
	input  wire logic         go,
	input  wire logic         ld,
	input  wire logic [139:0] word,
	input  wire logic [7:0]   n,
	output logic              serial_clk,
	output logic              serial_data,
	output logic              load_strobe,
	output logic              done
);
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b1;
		load_strobe = 1'b0;
		done = 1'b0;
	end

	// 30 ns link clock, offset so it never lines up with clk
	always @(posedge go) begin
		done = 1'b0;
		#7;
		for (int i = int'(n) - 1; i >= 0; i--) begin
			serial_data = word[i];
			#15 serial_clk = 1'b1;
			#15 serial_clk = 1'b0;
		end
		// released data line floats to its pull-up
		serial_data = 1'b1;
		if (ld) begin
			#15 load_strobe = 1'b1;
			#150 load_strobe = 1'b0;
		end
		#15 done = 1'b1;
	end
endmodule : host_model

// ### bench/clock_synth_loader_assertions.sv
// port-level checks of the serial control word loader
// assumes binding to clock_synth_loader; every check runs on clk
`timescale 1ns/1ns
`include "synth_cfg_map.svh"

module clock_synth_loader_assertions (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire logic                serial_clk,
	input wire logic                serial_data,
	input wire logic                load_strobe,
	input wire logic                power_down_pin_n,
	input wire logic [7:0]          address,
	input wire logic                read,
	input wire logic                write,
	input wire logic [31:0]         writedata,
	input wire logic [31:0]         readdata,
	input wire logic                waitrequest,
	input wire logic                first_clock_output,
	input wire logic                second_clock_output,
	input wire logic                third_clock_output,
	input wire logic                pll_running,
	input wire synth_cfg_pkg::cfg_s decoded_cfg
);
	import synth_cfg_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// sync, copy and decode all settle inside five quiet cycles
	sequence strobe_quiet;
		!load_strobe [*5];
	endsequence
	sequence pin_down;
		!power_down_pin_n [*4];
	endsequence

	a_read_answer: assert property ($rose(read) |=> !waitrequest)
		else $error("read not answered next cycle");
	a_answer_once: assert property (!waitrequest |=> waitrequest)
		else $error("answer longer than one cycle");
	a_word_holds: assert property (strobe_quiet |=> $stable(decoded_cfg))
		else $error("active word moved with strobe low");
	a_pin_stops: assert property (pin_down |-> !pll_running)
		else $error("running while pin holds power down");
	a_bit_stops: assert property (!decoded_cfg.vco_run [*3] |-> !pll_running)
		else $error("running with run bit clear");
	a_first_gated: assert property
		(!decoded_cfg.first_output_enable_bit [*3] |-> !first_clock_output)
		else $error("first output ticks while disabled");
	a_idle_quiet: assert property (!pll_running [*3] |-> !first_clock_output)
		else $error("first output ticks while stopped");
	a_fb_range: assert property ($past(rst_n) |->
		decoded_cfg.fb_div >= `FB_MIN && decoded_cfg.fb_div <= `FB_MAX)
		else $error("feedback divider out of range");
	a_ref_range: assert property ($past(rst_n) |->
		decoded_cfg.ref_div >= `REF_MIN && decoded_cfg.ref_div <= `REF_MAX)
		else $error("reference divider out of range");
endmodule : clock_synth_loader_assertions

bind clock_synth_loader clock_synth_loader_assertions u_chk (
	.clk(clk), .rst_n(rst_n), .serial_clk(serial_clk), .serial_data(serial_data),
	.load_strobe(load_strobe), .power_down_pin_n(power_down_pin_n), .address(address),
	.read(read), .write(write), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .first_clock_output(first_clock_output),
	.second_clock_output(second_clock_output), .third_clock_output(third_clock_output),
	.pll_running(pll_running), .decoded_cfg(decoded_cfg)
);

// ### bench/clock_synth_loader_tb.sv
// self-checking bench for the serial control word loader
// assumes host_model drives the serial port; the bench is the avalon master
`timescale 1ns/1ns
`include "synth_cfg_map.svh"

module clock_synth_loader_tb;
	import synth_cfg_pkg::*;
	logic         clk, rst_n, pin_n, read, write, waitrequest;
	logic         sck, sdi, lds, go, ld, done, o1, o2, o3, run;
	logic [7:0]   address, n;
	logic [31:0]  writedata, readdata, rd;
	logic [139:0] word;
	logic [131:0] w1, w3;
	cfg_s         cfg;
	int           n_mismatch, total_checks, c1, c2, c3;

	clock_synth_loader dut (
		.clk(clk), .rst_n(rst_n), .serial_clk(sck), .serial_data(sdi),
		.load_strobe(lds), .power_down_pin_n(pin_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .first_clock_output(o1),
		.second_clock_output(o2), .third_clock_output(o3), .pll_running(run),
		.decoded_cfg(cfg)
	);
	host_model host (.go(go), .ld(ld), .word(word), .n(n), .serial_clk(sck),
		.serial_data(sdi), .load_strobe(lds), .done(done));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask : chk

	task automatic tmo(input int k, input int lim);
		if (k >= lim) begin
			n_mismatch++;
			$display("FAIL %0t wait ran out", $time);
			results();
		end
	endtask : tmo

	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		read <= ~wr;
		write <= wr;
		address <= a;
		writedata <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		tmo(int'(waitrequest !== 1'b0), 1);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e, "read");
	endtask : rdchk

	task automatic act(input logic [131:0] w);
		logic [159:0] x;
		x = {28'h0, w};
		for (int i = 0; i < 5; i++)
			rdchk(8'(4 * i), x[32 * i +: 32]);
	endtask : act

	task automatic send(input logic [139:0] w, input logic [7:0] len, input logic l);
		int k;
		word <= w;
		n <= len;
		ld <= l;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (done !== 1'b1 && k < 400);
		tmo(int'(done !== 1'b1), 1);
		// load lands within about four clk after the strobe
		repeat (6) @(posedge clk);
	endtask : send

	task automatic rate(input int cyc);
		c1 = 0;
		c2 = 0;
		c3 = 0;
		repeat (cyc) begin
			@(posedge clk);
			c1 += int'(o1 === 1'b1);
			c2 += int'(o2 === 1'b1);
			c3 += int'(o3 === 1'b1);
		end
	endtask : rate

	function automatic logic [131:0] mk(input logic [11:0] v, r, od, input logic pr, oe);
		logic [131:0] w;
		w = `CW_DEFAULT;
		w[`FB_MSB:`FB_LSB] = v;
		w[`REF_MSB:`REF_LSB] = r;
		w[`OD1_MSB:`OD1_LSB] = od;
		w[`RUN_BIT] = pr;
		w[`OE1_BIT] = oe;
		return w;
	endfunction : mk

	initial begin
		rst_n = 1'b0;
		pin_n = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h0;
		go = 1'b0;
		ld = 1'b0;
		word = '0;
		n = 8'h00;
		n_mismatch = 0;
		total_checks = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		act(`CW_DEFAULT);
		rdchk(`ADDR_DIV, 32'h0006000c);
		rdchk(`ADDR_OD, 32'h04040002);
		rate(40);
		chk(32'(c1), 32'd40, "rate1");
		chk(32'(c2 >= 19 && c2 <= 21), 32'h1, "rate2");
		chk(32'(c3 >= 19 && c3 <= 21), 32'h1, "rate3");
		$display("test defaults done");
		// eight stale bits ahead of the word must fall off
		w1 = mk(12'h064, 12'h00a, 12'h014, 1'b1, 1'b1);
		send({8'ha5, w1}, 8'd140, 1'b1);
		act(w1);
		rdchk(`ADDR_DIV, 32'h000a0064);
		rdchk(`ADDR_STATUS, 32'h00010005);
		rate(40);
		chk(32'(c1 >= 19 && c1 <= 21), 32'h1, "rate1");
		$display("test load done");
		w3 = mk(12'h00c, 12'h006, 12'h002, 1'b0, 1'b0);
		send({8'h00, w3}, 8'd132, 1'b0);
		act(w1);
		bus(1'b1, `ADDR_ACT0, 32'hffffffff);
		rdchk(8'h40, 32'h0);
		act(w1);
		pin_n <= 1'b0;
		send(140'h0, 8'd0, 1'b1);
		act(w3);
		chk(32'(run), 32'h0, "run");
		rate(20);
		chk(32'(c1), 32'h0, "rate1");
		pin_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk(32'(run), 32'h0, "run");
		$display("test power down done");
		send({8'h00, mk(12'h005, 12'h000, 12'h002, 1'b1, 1'b1)}, 8'd132, 1'b1);
		rdchk(`ADDR_DIV, 32'h0001000c);
		chk(32'(cfg.fb_div), 32'd12, "fb");
		bus(1'b0, `ADDR_STATUS, 32'h0);
		chk(rd, 32'h0003001d, "status");
		$display("test clamp done");
		// running loop with the first output disabled
		send({8'h00, mk(12'h00c, 12'h006, 12'h002, 1'b1, 1'b0)}, 8'd132, 1'b1);
		chk(32'(run), 32'h1, "run");
		rate(20);
		chk(32'(c1), 32'h0, "rate1");
		// soft power down together with the load count clear
		bus(1'b1, `ADDR_CTRL, 32'h3);
		repeat (4) @(posedge clk);
		chk(32'(run), 32'h0, "run");
		rdchk(`ADDR_CTRL, 32'h1);
		rdchk(`ADDR_STATUS, 32'h00000004);
		$display("test enable and soft power down done");
		results();
	end
endmodule : clock_synth_loader_tb
